// file: hdl/spi_port_pkg.sv
// shared constants, layouts and types of the serial port
package spi_port_pkg;
  localparam int BYTE_BITS = 8; // bits in one transfer
  localparam int CLK_PERIOD_NS = 5; // system clock period
  localparam int SLAVE_SCK_MIN_DIV = 4; // lowest legal slave sampling ratio
  localparam int HALF_W = 7; // width of the half period counter
  localparam int EDGE_W = 4; // width of the sck edge counter
  localparam int BIT_W = 3; // width of the sample counter
  localparam logic [EDGE_W-1:0] LAST_EDGE = 4'hF; // sixteenth edge
  localparam logic [BIT_W-1:0] LAST_BIT = 3'h7; // eighth sample
  // half sck period in system clocks, normal speed, by rate select
  localparam logic [HALF_W-1:0] HALF_NORM_0 = 7'h02; // divide by 4
  localparam logic [HALF_W-1:0] HALF_NORM_1 = 7'h08; // divide by 16
  localparam logic [HALF_W-1:0] HALF_NORM_2 = 7'h20; // divide by 64
  localparam logic [HALF_W-1:0] HALF_NORM_3 = 7'h40; // divide by 128
  // half sck period, double speed
  localparam logic [HALF_W-1:0] HALF_DBL_0 = 7'h01; // divide by 2
  localparam logic [HALF_W-1:0] HALF_DBL_1 = 7'h04; // divide by 8
  localparam logic [HALF_W-1:0] HALF_DBL_2 = 7'h10; // divide by 32
  localparam logic [HALF_W-1:0] HALF_DBL_3 = 7'h20; // divide by 64
  localparam logic [BYTE_BITS-1:0] DATA_RESET = 8'h00; // data reset value
  localparam logic [3:0] SYNC_RESET = 4'h8; // pins at reset: select high

  // control bits as software writes them
  typedef struct packed {
    logic xfer_irq_enable; // request irq on done
    logic port_enable; // port on
    logic bit_order_sel; // 1: lsb first
    logic master_select; // 1: master role
    logic clock_polarity; // sck idle level
    logic clock_phase; // 1: sample trailing edge
    logic rate_sel_hi; // rate select high
    logic rate_sel_lo; // rate select low
    logic double_speed_bit; // halve divider
  } ctrl_s;
  localparam ctrl_s CTRL_RESET = '0; // all off after reset

  // status bits as software reads them
  typedef struct packed {
    logic xfer_done_flag; // byte done or mode fault
    logic write_collision; // write during transfer
    logic busy; // shift cycle running
  } status_s;

  // user pin directions, 1 = output
  typedef struct packed {
    logic mosi_out;
    logic miso_out;
    logic sck_out;
    logic ss_out;
  } pin_dir_s;

  typedef enum logic {ST_IDLE, ST_RUN} mst_state_e; // master clock states

  // half period from the three rate bits
  function automatic logic [HALF_W-1:0] half_cycles(input ctrl_s c);
    logic [HALF_W-1:0] h;
    h = HALF_NORM_0;
    case ({c.double_speed_bit, c.rate_sel_hi, c.rate_sel_lo})
      3'h0: h = HALF_NORM_0;
      3'h1: h = HALF_NORM_1;
      3'h2: h = HALF_NORM_2;
      3'h3: h = HALF_NORM_3;
      3'h4: h = HALF_DBL_0;
      3'h5: h = HALF_DBL_1;
      3'h6: h = HALF_DBL_2;
      default: h = HALF_DBL_3;
    endcase
    return h;
  endfunction
endpackage

// file: hdl/spi_sync2.sv
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module spi_sync2 #(
  parameter int W = 4,
  parameter logic [W-1:0] RESET_VAL = '0
) (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);
  logic [W-1:0] meta_reg; // first stage, read only by second

  // two stages, nothing taps the first
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      meta_reg <= RESET_VAL;
      o_sync <= RESET_VAL;
    end else begin
      meta_reg <= i_async;
      o_sync <= meta_reg;
    end
  end
endmodule // spi_sync2

// file: hdl/spi_master_slave_port.sv
// byte wide full duplex serial port, master or slave role
// Behaviour
// - master never drives select on its own
// - master data write clocks out eight bits
// - after byte, clock stops, done flag set
// - done flag with enable raises irq
// - last received byte held in buffer
// - slave with select high: idle, miso off
// - slave shifts loaded byte only when selected
// - slave sets done flag after full byte
// - slave takes new byte before rx read
// - single tx buffer, busy write is refused
// - unread received byte overwritten by next
// - mosi master to slave, miso back, together
// - enabled port gates user pin directions by role
// - seven master rates including divide by two
// - bit order lsb or msb first
// - done interrupt can wake from idle
// - select rise resets slave shift logic
// - low select input drops master, sets flag
// - rate from double speed and two bits
// - polarity sets idle, phase picks sample edge
`timescale 1ns/1ps
module spi_master_slave_port (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire spi_port_pkg::ctrl_s i_ctrl,
  input wire logic i_ctrl_wr,
  input wire logic [spi_port_pkg::BYTE_BITS-1:0] i_wdata,
  input wire logic i_data_wr,
  input wire logic i_data_rd,
  input wire logic i_status_rd,
  input wire spi_port_pkg::pin_dir_s i_pin_dir,
  input wire logic i_ss_out_val,
  output spi_port_pkg::ctrl_s o_ctrl,
  output spi_port_pkg::status_s o_status,
  output logic [spi_port_pkg::BYTE_BITS-1:0] o_rx_data,
  output logic o_irq,
  input wire logic i_sck,
  input wire logic i_mosi,
  input wire logic i_miso,
  input wire logic i_ss_n,
  output logic o_sck,
  output logic o_sck_oe_n,
  output logic o_mosi,
  output logic o_mosi_oe_n,
  output logic o_miso,
  output logic o_miso_oe_n,
  output logic o_ss_n,
  output logic o_ss_oe_n
);
  import spi_port_pkg::*;

  ctrl_s ctrl_reg; // control bits
  mst_state_e state_reg; // master clock state
  logic [HALF_W-1:0] div_reg; // half period down counter
  logic [EDGE_W-1:0] edge_reg; // master sck edges done
  logic sck_reg; // master sck level
  logic [BIT_W-1:0] bit_reg; // samples in this byte
  logic [BYTE_BITS-1:0] shift_reg; // shared shift register
  logic [BYTE_BITS-1:0] tx_hold_reg; // copy of last byte written while not busy
  logic [BYTE_BITS-1:0] rx_reg; // receive buffer
  logic out_reg; // serial data out bit
  logic flag_reg; // done flag
  logic wcol_reg; // write collision flag
  logic armed_reg; // status read seen with flag up
  logic sck_prev_reg; // last synced sck
  logic ss_prev_reg; // last synced select
  logic [3:0] sync_out; // synced pins
  logic ss_s, sck_s, mosi_s, miso_s; // synced pin levels

  // all pin inputs cross into the system clock
  spi_sync2 #(.W(4), .RESET_VAL(SYNC_RESET)) u_sync (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_async({i_ss_n, i_sck, i_mosi, i_miso}),
    .o_sync(sync_out)
  );
  assign {ss_s, sck_s, mosi_s, miso_s} = sync_out;

  // role and event decode
  logic master, slave, slave_sel, running, mode_fault, busy;
  logic tick, last_tick, m_lead, s_edge, s_lead, ev, lead;
  logic sample_ev, setup_ev, in_bit, wr_ok, start, ss_rise;
  logic byte_done, m_done, s_done;
  logic [BYTE_BITS-1:0] shift_next;

  // first bit on the wire for the chosen order
  function automatic logic front_bit(input logic lsb_first,
                                     input logic [BYTE_BITS-1:0] d);
    return lsb_first ? d[0] : d[BYTE_BITS-1];
  endfunction

  assign master = ctrl_reg.port_enable & ctrl_reg.master_select;
  assign slave = ctrl_reg.port_enable & ~ctrl_reg.master_select;
  assign slave_sel = slave & ~ss_s;
  assign running = (state_reg == ST_RUN);
  // select used as input pulled low while master
  assign mode_fault = master & ~i_pin_dir.ss_out & ~ss_s;
  // mid byte in either role
  assign busy = running | (slave_sel & (bit_reg != '0));
  assign wr_ok = i_data_wr & ~busy;
  assign start = master & wr_ok & ~mode_fault;
  assign ss_rise = ss_s & ~ss_prev_reg;

  // master edges from the divider
  assign tick = running & (div_reg == '0);
  assign last_tick = tick & (edge_reg == LAST_EDGE);
  assign m_lead = ~edge_reg[0];
  // slave edges from sampled sck, only while selected
  assign s_edge = slave_sel & (sck_s != sck_prev_reg);
  assign s_lead = (sck_s != ctrl_reg.clock_polarity);
  assign ev = master ? tick : s_edge;
  assign lead = master ? m_lead : s_lead;
  // phase 0 samples leading, phase 1 trailing
  assign sample_ev = ev & (lead ^ ctrl_reg.clock_phase);
  assign setup_ev = ev & ~(lead ^ ctrl_reg.clock_phase);
  // master listens on miso, slave on mosi
  assign in_bit = master ? miso_s : mosi_s;
  assign byte_done = sample_ev & (bit_reg == LAST_BIT);
  assign m_done = master & last_tick;
  assign s_done = slave & byte_done;

  // next shift value, order chosen by software
  always_comb begin
    if (ctrl_reg.bit_order_sel) begin
      shift_next = {in_bit, shift_reg[BYTE_BITS-1:1]};
    end else begin
      shift_next = {shift_reg[BYTE_BITS-2:0], in_bit};
    end
  end

  // control bits; a mode fault drops master role
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      ctrl_reg <= CTRL_RESET;
    end else begin
      if (i_ctrl_wr) begin
        ctrl_reg <= i_ctrl;
      end
      if (mode_fault) begin
        ctrl_reg.master_select <= 1'b0;
      end
    end
  end

  // master clock generator, stops after one byte
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      state_reg <= ST_IDLE;
      div_reg <= '0;
      edge_reg <= '0;
      sck_reg <= 1'b0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          // a control write moves the idle level on the same edge
          sck_reg <= i_ctrl_wr ? i_ctrl.clock_polarity
                               : ctrl_reg.clock_polarity;
          edge_reg <= '0;
          if (start) begin
            state_reg <= ST_RUN;
            div_reg <= half_cycles(ctrl_reg) - 1'b1;
          end
        end
        default: begin
          if (~master | mode_fault) begin
            // role lost mid byte: stop at idle level
            state_reg <= ST_IDLE;
            sck_reg <= ctrl_reg.clock_polarity;
          end else if (tick) begin
            sck_reg <= ~sck_reg;
            edge_reg <= edge_reg + 1'b1;
            div_reg <= half_cycles(ctrl_reg) - 1'b1;
            if (last_tick) begin
              state_reg <= ST_IDLE;
            end
          end else begin
            div_reg <= div_reg - 1'b1;
          end
        end
      endcase
    end
  end

  // pin history for edge detection
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      sck_prev_reg <= 1'b0;
      ss_prev_reg <= 1'b1;
    end else begin
      sck_prev_reg <= sck_s;
      ss_prev_reg <= ss_s;
    end
  end

  // sample counter, cleared whenever no byte can run
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      bit_reg <= '0;
    end else if (~slave_sel & ~running) begin
      bit_reg <= '0;
    end else if (sample_ev) begin
      bit_reg <= (bit_reg == LAST_BIT) ? '0 : bit_reg + 1'b1;
    end
  end

  // shift register: loaded by write, restored on deselect
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      shift_reg <= DATA_RESET;
      tx_hold_reg <= DATA_RESET;
    end else if (wr_ok) begin
      shift_reg <= i_wdata;
      tx_hold_reg <= i_wdata;
    end else if (slave & ss_rise) begin
      shift_reg <= tx_hold_reg;
    end else if (sample_ev) begin
      shift_reg <= shift_next;
    end
  end

  // serial out bit, loaded by write or slave deselect, else moves on setup edges
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      out_reg <= 1'b0;
    end else if (wr_ok) begin
      out_reg <= front_bit(ctrl_reg.bit_order_sel, i_wdata);
    end else if (slave & ss_rise) begin
      out_reg <= front_bit(ctrl_reg.bit_order_sel, tx_hold_reg);
    end else if (setup_ev) begin
      out_reg <= front_bit(ctrl_reg.bit_order_sel, shift_reg);
    end
  end

  // receive buffer, newest byte overwrites unread one
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      rx_reg <= DATA_RESET;
    end else if (byte_done) begin
      rx_reg <= shift_next;
    end
  end

  // status read then data access clears the flags
  logic clear_ev;
  assign clear_ev = armed_reg & (i_data_rd | i_data_wr);

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      armed_reg <= 1'b0;
    end else if (clear_ev) begin
      armed_reg <= 1'b0;
    end else if (i_status_rd & (flag_reg | wcol_reg)) begin
      armed_reg <= 1'b1;
    end
  end

  // done flag, a new event beats the clear
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      flag_reg <= 1'b0;
    end else if (m_done | s_done | mode_fault) begin
      flag_reg <= 1'b1;
    end else if (clear_ev) begin
      flag_reg <= 1'b0;
    end
  end

  // collision flag for writes into a running byte
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      wcol_reg <= 1'b0;
    end else if (i_data_wr & busy) begin
      wcol_reg <= 1'b1;
    end else if (clear_ev) begin
      wcol_reg <= 1'b0;
    end
  end

  // software visible state
  assign o_ctrl = ctrl_reg;
  assign o_status = '{xfer_done_flag: flag_reg, write_collision: wcol_reg,
                      busy: busy};
  assign o_rx_data = rx_reg;
  // level request, also serves as idle wake source
  assign o_irq = flag_reg & ctrl_reg.xfer_irq_enable;

  // pin values and role gated user directions
  assign o_sck = sck_reg;
  assign o_mosi = out_reg;
  assign o_miso = out_reg;
  assign o_ss_n = i_ss_out_val;
  assign o_mosi_oe_n = ~(master & i_pin_dir.mosi_out);
  assign o_sck_oe_n = ~(master & i_pin_dir.sck_out);
  assign o_ss_oe_n = ~(master & i_pin_dir.ss_out);
  assign o_miso_oe_n = ~(slave_sel & i_pin_dir.miso_out);

  // checks
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);

  logic [4:0] tog_reg; // sck toggles in current master byte
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      tog_reg <= '0;
    end else if (start) begin
      tog_reg <= '0;
    end else if (running & tick) begin
      tog_reg <= tog_reg + 1'b1;
    end
  end

  AST_START_BUSY: assert property (start |=> o_status.busy)
    else $error("master write did not start a byte");
  AST_SIXTEEN_EDGES: assert property (
    $past(m_done) |-> tog_reg == 5'h10)
    else $error("master byte not sixteen sck edges");
  AST_DONE_STOP: assert property (
    m_done |=> !running && o_status.xfer_done_flag)
    else $error("clock not stopped or flag not set");
  AST_IRQ: assert property (
    $rose(flag_reg) && ctrl_reg.xfer_irq_enable |-> o_irq)
    else $error("done flag did not raise irq");
  AST_RX_HOLD: assert property (
    byte_done |=> o_rx_data == $past(shift_next))
    else $error("received byte not held");
  AST_MISO_OFF: assert property (slave && ss_s |-> o_miso_oe_n)
    else $error("miso driven while deselected");
  AST_NO_SHIFT_DESEL: assert property (
    slave && ss_s && ss_prev_reg && !i_data_wr |=> $stable(shift_reg))
    else $error("shift while deselected");
  AST_SLAVE_FLAG: assert property (s_done |=> o_status.xfer_done_flag)
    else $error("slave flag not set");
  AST_WCOL: assert property (
    i_data_wr && busy |=> wcol_reg && $past(tx_hold_reg) == tx_hold_reg)
    else $error("busy write not refused");
  AST_SS_RESET: assert property (slave && ss_rise |=> bit_reg == '0)
    else $error("select rise kept partial bits");
  AST_FAULT: assert property (
    mode_fault |=> !ctrl_reg.master_select && flag_reg)
    else $error("mode fault not handled");
  AST_MST_MISO_IN: assert property (master |-> o_miso_oe_n)
    else $error("master drives miso");
  AST_SCK_IDLE: assert property (
    !running [*2] |-> o_sck == ctrl_reg.clock_polarity)
    else $error("sck not at idle level");

  COV_MASTER_BYTE: cover property (m_done);
  COV_SLAVE_BYTE: cover property (s_done);
  COV_FAULT: cover property (mode_fault);
  COV_WCOL: cover property (i_data_wr && busy);
endmodule // spi_master_slave_port

// file: verification/spi_peer_model.sv
// behavioural serial peripheral that answers the port in master role
`timescale 1ns/1ps
module spi_peer_model (
  input wire logic i_sck, // serial clock pin
  input wire logic i_mosi, // data from the master
  input wire logic i_ss_n, // select pin, active low
  input wire logic i_pol, // sck idle level
  input wire logic i_pha, // 1: sample on trailing edge
  input wire logic i_lsb_first, // wire bit order
  input wire logic [7:0] i_tx_byte, // byte sent back
  output logic o_miso, // data to the master
  output logic [7:0] o_rx_byte // last byte taken from mosi
);
  int out_idx; // next reply bit to drive

  // reply bit k in wire order
  function automatic logic pick(input int k);
    return i_lsb_first ? i_tx_byte[k] : i_tx_byte[7-k];
  endfunction

  initial begin
    o_miso = 1'b1;
    o_rx_byte = 8'h00;
    out_idx = 0;
  end

  // select edges: phase 0 puts first bit up front, or line inverted on deselect
  always @(i_ss_n) begin
    if (i_ss_n === 1'b0) begin
      out_idx = 0;
      if (!i_pha) begin
        o_miso = pick(0);
        out_idx = 1;
      end
    end else begin
      o_miso = ~o_miso; // deselect inverts the line so it never keeps a stale bit
    end
  end

  // sck edges: sample on one kind, set up on the other
  always @(i_sck) begin
    if (i_ss_n === 1'b0) begin
      if ((i_sck != i_pol) ^ i_pha) begin
        o_rx_byte = i_lsb_first ? {i_mosi, o_rx_byte[7:1]}
                                : {o_rx_byte[6:0], i_mosi};
      end else if (out_idx < 8) begin
        o_miso = pick(out_idx);
        out_idx = out_idx + 1;
      end
    end
  end
endmodule // spi_peer_model

// file: verification/spi_master_slave_port_tb.sv
// self-checking bench of the master or slave serial port
`timescale 1ns/1ps
module spi_master_slave_port_tb;
  import spi_port_pkg::*;
  localparam int HT[8] = '{2, 8, 32, 64, 1, 4, 16, 32}; // half periods
  localparam logic [7:0] TXB[8] = '{8'hA3, 8'h5C, 8'h81, 8'h7E,
                                    8'h96, 8'h0F, 8'hC1, 8'h3A};
  localparam int TIME_LIMIT = 20000; // cycle ceiling for a hang
  logic i_ref_clk = 1'b0;
  logic i_rst = 1'b1;
  ctrl_s i_ctrl = CTRL_RESET;
  logic i_ctrl_wr = 1'b0;
  logic [7:0] i_wdata = 8'h00;
  logic i_data_wr = 1'b0;
  logic i_data_rd = 1'b0;
  logic i_status_rd = 1'b0;
  pin_dir_s i_pin_dir = '0;
  logic i_ss_out_val = 1'b1;
  ctrl_s o_ctrl;
  status_s o_status;
  logic [7:0] o_rx_data;
  logic o_irq, o_sck, o_sck_oe_n, o_mosi, o_mosi_oe_n;
  logic o_miso, o_miso_oe_n, o_ss_n, o_ss_oe_n;
  logic ext_sck = 1'b0; // external master lines
  logic ext_mosi = 1'b0;
  logic ext_ss_n = 1'b1;
  logic [7:0] peer_tx = 8'h00; // peer reply byte
  logic [7:0] peer_rx;
  logic peer_miso;
  logic sck_pin, mosi_pin, miso_pin, ss_pin; // resolved wire levels
  int mismatches = 0;
  int checked = 0;
  int cycles = 0;

  // whoever enables drives the wire, else the outside party
  assign sck_pin = o_sck_oe_n ? ext_sck : o_sck;
  assign mosi_pin = o_mosi_oe_n ? ext_mosi : o_mosi;
  assign miso_pin = o_miso_oe_n ? peer_miso : o_miso;
  assign ss_pin = o_ss_oe_n ? ext_ss_n : o_ss_n;

  spi_master_slave_port spi_master_slave_port_i (
    .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_ctrl(i_ctrl),
    .i_ctrl_wr(i_ctrl_wr), .i_wdata(i_wdata), .i_data_wr(i_data_wr),
    .i_data_rd(i_data_rd), .i_status_rd(i_status_rd),
    .i_pin_dir(i_pin_dir), .i_ss_out_val(i_ss_out_val),
    .o_ctrl(o_ctrl), .o_status(o_status), .o_rx_data(o_rx_data),
    .o_irq(o_irq), .i_sck(sck_pin), .i_mosi(mosi_pin),
    .i_miso(miso_pin), .i_ss_n(ss_pin), .o_sck(o_sck),
    .o_sck_oe_n(o_sck_oe_n), .o_mosi(o_mosi), .o_mosi_oe_n(o_mosi_oe_n),
    .o_miso(o_miso), .o_miso_oe_n(o_miso_oe_n), .o_ss_n(o_ss_n),
    .o_ss_oe_n(o_ss_oe_n));

  spi_peer_model spi_peer_model_i (
    .i_sck(sck_pin), .i_mosi(mosi_pin), .i_ss_n(ss_pin),
    .i_pol(i_ctrl.clock_polarity), .i_pha(i_ctrl.clock_phase),
    .i_lsb_first(i_ctrl.bit_order_sel), .i_tx_byte(peer_tx),
    .o_miso(peer_miso), .o_rx_byte(peer_rx));

  // 200 MHz system clock
  always #2.5 i_ref_clk = ~i_ref_clk;

  // hang guard
  always @(posedge i_ref_clk) begin
    cycles++;
    if (cycles == TIME_LIMIT) begin
      mismatches++;
      final_report();
    end
  end

  task automatic final_report;
    $display("checks %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge i_ref_clk);
  endtask

  // control word: irq and port on, role, mode, order, rate
  function automatic ctrl_s mk(input logic ms, input logic [1:0] md,
                               input logic lsb, input logic [2:0] rt);
    ctrl_s c;
    c = CTRL_RESET;
    c.xfer_irq_enable = 1'b1;
    c.port_enable = 1'b1;
    c.master_select = ms;
    {c.clock_polarity, c.clock_phase} = md;
    c.bit_order_sel = lsb;
    {c.double_speed_bit, c.rate_sel_hi, c.rate_sel_lo} = rt;
    return c;
  endfunction

  task automatic set_ctrl(input ctrl_s c);
    @(posedge i_ref_clk);
    i_ctrl <= c;
    i_ctrl_wr <= 1'b1;
    @(posedge i_ref_clk);
    i_ctrl_wr <= 1'b0;
  endtask

  task automatic wr_data(input logic [7:0] b);
    @(posedge i_ref_clk);
    i_wdata <= b;
    i_data_wr <= 1'b1;
    @(posedge i_ref_clk);
    i_data_wr <= 1'b0;
  endtask

  // cycles from the taking edge until the flag shows
  task automatic wait_done(output int n);
    n = 0;
    do begin
      @(posedge i_ref_clk);
      #1;
      n++;
    end while (o_status.xfer_done_flag !== 1'b1 && n < 3000);
  endtask

  // status read then data read clears both flags
  task automatic clear_flag;
    @(posedge i_ref_clk);
    i_status_rd <= 1'b1;
    @(posedge i_ref_clk);
    i_status_rd <= 1'b0;
    i_data_rd <= 1'b1;
    @(posedge i_ref_clk);
    i_data_rd <= 1'b0;
    tick(1);
    #1;
    check("flags cleared", {o_status.xfer_done_flag,
          o_status.write_collision}, 2'h0);
  endtask

  // external master, mode 0, msb first, nb bits then deselect
  task automatic ext_xfer(input logic [7:0] b, input int nb,
                          output logic [7:0] got);
    got = 8'h00;
    @(posedge i_ref_clk);
    ext_ss_n <= 1'b0;
    for (int i = 7; i > 7 - nb; i--) begin
      ext_mosi <= b[i];
      tick(6);
      ext_sck <= 1'b1;
      got = {got[6:0], miso_pin};
      tick(6);
      ext_sck <= 1'b0;
    end
    tick(8);
    check("miso driven", o_miso_oe_n, 1'b0);
    ext_ss_n <= 1'b1;
    tick(6);
  endtask

  initial begin
    int n;
    logic [7:0] got;
    repeat (6) @(posedge i_ref_clk);
    #1;
    check("reset ctrl", o_ctrl, CTRL_RESET);
    check("reset status", o_status, 3'h0);
    check("reset pins", {o_irq, o_sck, o_sck_oe_n, o_mosi_oe_n,
          o_miso_oe_n, o_ss_oe_n}, 6'h0F);
    check("reset rx", o_rx_data, DATA_RESET);
    @(posedge i_ref_clk);
    i_rst <= 1'b0;
    i_pin_dir <= pin_dir_s'(4'hB);
    $display("test reset done");
    // master: every mode and both bit orders
    for (int m = 0; m < 8; m++) begin
      set_ctrl(mk(1'b1, m[1:0], m[2], 3'h1));
      peer_tx <= TXB[7-m];
      tick(2); // idle sck settles before the peer is selected
      i_ss_out_val <= 1'b0;
      tick(4);
      check("ss follows sw", {o_ss_n, o_ss_oe_n}, 2'h0);
      wr_data(TXB[m]);
      wait_done(n);
      check("byte cycles", n, 16 * HT[1]);
      check("irq", o_irq, 1'b1);
      check("busy off", o_status.busy, 1'b0);
      check("peer rx", peer_rx, TXB[m]);
      check("master rx", o_rx_data, TXB[7-m]);
      check("sck idle", o_sck, m[1]);
      check("master dirs", {o_sck_oe_n, o_mosi_oe_n, o_miso_oe_n},
            3'h1);
      @(posedge i_ref_clk);
      i_ss_out_val <= 1'b1;
      clear_flag();
    end
    $display("test master modes done");
    // every rate code
    for (int r = 0; r < 8; r++) begin
      set_ctrl(mk(1'b1, 2'h0, 1'b0, r[2:0]));
      i_ss_out_val <= 1'b0;
      wr_data(8'h55);
      wait_done(n);
      check("rate cycles", n, 16 * HT[r]);
      @(posedge i_ref_clk);
      i_ss_out_val <= 1'b1;
      clear_flag();
    end
    $display("test rates done");
    // write while busy is refused
    set_ctrl(mk(1'b1, 2'h0, 1'b0, 3'h0));
    i_ss_out_val <= 1'b0;
    wr_data(8'h3C);
    tick(3);
    wr_data(8'hC3);
    tick(1);
    #1;
    check("collision", {o_status.write_collision, o_status.busy},
          2'h3);
    wait_done(n);
    check("first byte kept", peer_rx, 8'h3C);
    @(posedge i_ref_clk);
    i_ss_out_val <= 1'b1;
    clear_flag();
    $display("test collision done");
    // select input pulled low while master
    @(posedge i_ref_clk);
    i_pin_dir <= pin_dir_s'(4'hA);
    ext_ss_n <= 1'b0;
    wait_done(n);
    check("fault flag", {o_ctrl.master_select, o_irq}, 2'h1);
    check("fault dirs", {o_sck_oe_n, o_mosi_oe_n}, 2'h3);
    @(posedge i_ref_clk);
    ext_ss_n <= 1'b1;
    clear_flag();
    $display("test mode fault done");
    // slave role
    set_ctrl(mk(1'b0, 2'h0, 1'b0, 3'h0));
    i_pin_dir <= pin_dir_s'(4'h4);
    tick(4);
    check("slave idle", {o_miso_oe_n, o_sck_oe_n, o_mosi_oe_n},
          3'h7);
    wr_data(8'h96);
    repeat (4) begin
      @(posedge i_ref_clk);
      ext_sck <= ~ext_sck;
      tick(6);
    end
    ext_xfer(8'h5A, 8, got);
    check("slave tx", got, 8'h96);
    check("slave rx", o_rx_data, 8'h5A);
    check("slave flag", {o_status.xfer_done_flag, o_irq}, 2'h3);
    wr_data(8'h21);
    ext_xfer(8'hE7, 8, got);
    check("tx before rx read", got, 8'h21);
    check("rx overwritten", o_rx_data, 8'hE7);
    clear_flag();
    ext_xfer(8'hFF, 3, got);
    check("partial no flag", o_status.xfer_done_flag, 1'b0);
    wr_data(8'h4B);
    ext_xfer(8'h18, 8, got);
    check("resync rx", o_rx_data, 8'h18);
    check("resync tx", got, 8'h4B);
    $display("test slave done");
    final_report();
  end
endmodule // spi_master_slave_port_tb
